// ---- rtl/dsmd_params.svh ----
// dsmd_params.svh: timing constants and level codes for the mode detector
// assumes inclusion by the package and the main module only
`ifndef DSMD_PARAMS_SVH
`define DSMD_PARAMS_SVH

`define DSMD_CLK_HZ 20000000
`define DSMD_QUAL_MS 100
`define DSMD_QUAL_CYC ((`DSMD_CLK_HZ / 1000) * `DSMD_QUAL_MS)
`define DSMD_CMP_SE_BIT 0
`define DSMD_CMP_LVD_BIT 1
`define DSMD_CMP_HVD_BIT 2
`define DSMD_RESET_MODE 4'h1

`endif

// ---- rtl/dsmd_pkg.sv ----
// dsmd_pkg.sv: types shared by the mode detector
// assumes dsmd_params.svh is on the include path
`include "dsmd_params.svh"

package dsmd_pkg;

    typedef enum logic [3:0]
    {
        DSMD_MODE_IND = 4'h1,
        DSMD_MODE_SE = 4'h2,
        DSMD_MODE_LVD = 4'h4,
        DSMD_MODE_HVD = 4'h8
    } dsmd_mode_type;

    typedef enum logic [2:0]
    {
        DSMD_ST_POWER = 3'h1,
        DSMD_ST_SETTLE = 3'h2,
        DSMD_ST_RUN = 3'h4
    } dsmd_state_type;

endpackage : dsmd_pkg

// ---- rtl/dsmd_sync.sv ----
// dsmd_sync.sv: two-flop synchroniser for comparator levels
// assumes inputs are asynchronous to core_clk_i
`timescale 1ns/1ps

module dsmd_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // data
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    always_comb
    begin
        nxt_meta = async_i;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_o = sync_ff;

endmodule : dsmd_sync

// ---- rtl/dsmd_detect.sv ----
// dsmd_detect.sv: diffsens mode qualification and driver gating
// assumes three window comparators, each high when the level is in its band
`timescale 1ns/1ps
`include "dsmd_params.svh"

module dsmd_detect
    import dsmd_pkg::*;
#(
    parameter int QUAL_CYC = `DSMD_QUAL_CYC
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // comparator bands from the diffsens front end
    input wire logic cmp_se_i,
    input wire logic cmp_lvd_i,
    input wire logic cmp_hvd_i,
    // diffsens lvd source
    output logic diffsens_drv_en_o,
    // transceiver and terminator control
    output logic drivers_en_o,
    output logic mode_se_o,
    output logic mode_lvd_o,
    output logic mode_hvd_o,
    output logic term_lvd_en_o,
    output logic term_se_en_o,
    output logic gnd_drv_en_o,
    // status
    output logic ready_o
);

    // elaboration check, counters need two states at least
    if (QUAL_CYC < 2)
    begin : g_qual_chk
        $error("QUAL_CYC too small");
    end

    localparam int CW = $clog2(QUAL_CYC + 1);
    localparam logic [CW-1:0] QUAL_LAST = CW'(QUAL_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    // input synchronising and classification

    logic [2:0] cmp_sync;

    dsmd_sync #(
        .WIDTH(3)
    ) u_sync (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .async_i({cmp_hvd_i, cmp_lvd_i, cmp_se_i}),
        .sync_o(cmp_sync)
    );

    function automatic dsmd_mode_type classify(input logic [2:0] c);
        dsmd_mode_type m;
        m = DSMD_MODE_IND;
        // exactly one band must be hit, else gap
        if (c == 3'h1 << `DSMD_CMP_SE_BIT)
            m = DSMD_MODE_SE;
        else if (c == 3'h1 << `DSMD_CMP_LVD_BIT)
            m = DSMD_MODE_LVD;
        else if (c == 3'h1 << `DSMD_CMP_HVD_BIT)
            m = DSMD_MODE_HVD;
        else
            m = DSMD_MODE_IND;
        return m;
    endfunction : classify

    dsmd_mode_type raw_mode;

    assign raw_mode = classify(cmp_sync);

    ////////////////////////////////////////////////////////////////////////
    // qualification timer and accepted mode

    dsmd_state_type state_ff;
    dsmd_state_type nxt_state;
    dsmd_mode_type cand_ff;
    dsmd_mode_type nxt_cand;
    dsmd_mode_type mode_ff;
    dsmd_mode_type nxt_mode;
    logic [CW-1:0] pwr_cnt_ff;
    logic [CW-1:0] nxt_pwr_cnt;
    logic [CW-1:0] qual_cnt_ff;
    logic [CW-1:0] nxt_qual_cnt;
    logic qual_done;

    assign qual_done = (qual_cnt_ff == QUAL_LAST)
        && (raw_mode == cand_ff) && (raw_mode != DSMD_MODE_IND);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cand = raw_mode;
        nxt_mode = mode_ff;
        nxt_pwr_cnt = pwr_cnt_ff;
        nxt_qual_cnt = '0;
        // restart when raw mode moves or is indeterminate
        if (raw_mode == cand_ff && raw_mode != DSMD_MODE_IND)
        begin
            if (qual_cnt_ff != QUAL_LAST)
                nxt_qual_cnt = qual_cnt_ff + CW'(1);
            else
                nxt_qual_cnt = qual_cnt_ff;
        end
        case (state_ff)
            DSMD_ST_POWER:
            begin
                // count logic-operational time
                if (pwr_cnt_ff == QUAL_LAST)
                begin
                    nxt_state = DSMD_ST_SETTLE;
                    nxt_qual_cnt = '0;
                end
                else
                    nxt_pwr_cnt = pwr_cnt_ff + CW'(1);
            end
            DSMD_ST_SETTLE:
            begin
                // stable mode for a full further interval
                if (qual_done)
                begin
                    nxt_state = DSMD_ST_RUN;
                    nxt_mode = cand_ff;
                end
            end
            DSMD_ST_RUN:
            begin
                // old mode held until new one qualifies
                if (qual_done && cand_ff != mode_ff)
                    nxt_mode = cand_ff;
            end
            default:
                nxt_state = DSMD_ST_POWER;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_ff <= DSMD_ST_POWER;
            cand_ff <= DSMD_MODE_IND;
            mode_ff <= dsmd_mode_type'(`DSMD_RESET_MODE);
            pwr_cnt_ff <= '0;
            qual_cnt_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            cand_ff <= nxt_cand;
            mode_ff <= nxt_mode;
            pwr_cnt_ff <= nxt_pwr_cnt;
            qual_cnt_ff <= nxt_qual_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output decode, all registered

    logic run;
    logic nxt_drv_en;
    logic nxt_se;
    logic nxt_lvd;
    logic nxt_hvd;
    logic nxt_ready;
    logic drv_en_ff;
    logic se_ff;
    logic lvd_ff;
    logic hvd_ff;
    logic ready_ff;
    logic dsdrv_ff;

    assign run = (nxt_state == DSMD_ST_RUN);

    always_comb
    begin
        nxt_ready = run;
        nxt_se = run && (nxt_mode == DSMD_MODE_SE);
        nxt_lvd = run && (nxt_mode == DSMD_MODE_LVD);
        nxt_hvd = run && (nxt_mode == DSMD_MODE_HVD);
        // drivers stay off before qualification and in hvd
        nxt_drv_en = run && (nxt_mode != DSMD_MODE_HVD);
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            drv_en_ff <= 1'b0;
            se_ff <= 1'b0;
            lvd_ff <= 1'b0;
            hvd_ff <= 1'b0;
            ready_ff <= 1'b0;
            dsdrv_ff <= 1'b0;
        end
        else
        begin
            drv_en_ff <= nxt_drv_en;
            se_ff <= nxt_se;
            lvd_ff <= nxt_lvd;
            hvd_ff <= nxt_hvd;
            ready_ff <= nxt_ready;
            // lvd source runs while sensing continues
            dsdrv_ff <= 1'b1;
        end
    end

    assign diffsens_drv_en_o = dsdrv_ff;
    assign drivers_en_o = drv_en_ff;
    assign mode_se_o = se_ff;
    assign mode_lvd_o = lvd_ff;
    assign mode_hvd_o = hvd_ff;
    assign term_lvd_en_o = lvd_ff;
    assign term_se_en_o = se_ff;
    assign gnd_drv_en_o = se_ff;
    assign ready_o = ready_ff;

endmodule : dsmd_detect

// ---- dv/dsmd_detect_chk.sv ----
// dsmd_detect_chk.sv: port assertions for the mode detector
// assumes bound into dsmd_detect, qual count handed on
`timescale 1ns/1ps

module dsmd_detect_chk #(
    parameter int QUAL_CYC = 8
) (
    // clock, reset, comparators
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic cmp_se_i,
    input wire logic cmp_lvd_i,
    input wire logic cmp_hvd_i,
    // outputs watched
    input wire logic diffsens_drv_en_o,
    input wire logic drivers_en_o,
    input wire logic mode_se_o,
    input wire logic mode_lvd_o,
    input wire logic mode_hvd_o,
    input wire logic term_lvd_en_o,
    input wire logic term_se_en_o,
    input wire logic gnd_drv_en_o,
    input wire logic ready_o
);
    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic se_only;
    assign se_only = cmp_se_i & !cmp_lvd_i & !cmp_hvd_i;
    always_comb
    begin
        nxt_cnt = cnt_ff + ((cnt_ff < 32'hffffffff) ? 32'h1 : 32'h0);
    end
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            cnt_ff <= 32'h0;
        else
            cnt_ff <= nxt_cnt;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    //////////////////////////////
    drv_src_a: assert property (
        $past(reset_n_i) |-> diffsens_drv_en_o)
        else $error("diffsens source off");
    mode_one_a: assert property (
        $onehot0({mode_se_o, mode_lvd_o, mode_hvd_o}))
        else $error("several modes");
    power_wait_a: assert property (
        $rose(ready_o) |-> cnt_ff >= 2*QUAL_CYC)
        else $error("ready too early");
    drv_ready_a: assert property (
        drivers_en_o |-> ready_o)
        else $error("drivers before ready");
    se_qual_a: assert property (
        $rose(mode_se_o) |-> $past(se_only, 5))
        else $error("se taken unqualified");
    term_lvd_a: assert property (
        term_lvd_en_o == mode_lvd_o)
        else $error("lvd term mismatch");
    term_se_a: assert property (
        term_se_en_o == mode_se_o)
        else $error("se term mismatch");
    gnd_se_a: assert property (
        gnd_drv_en_o == mode_se_o)
        else $error("ground driver mismatch");
    hvd_off_a: assert property (
        mode_hvd_o |-> !drivers_en_o)
        else $error("drivers on in hvd");
endmodule : dsmd_detect_chk

bind dsmd_detect dsmd_detect_chk #(.QUAL_CYC(QUAL_CYC)) chk_u (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .cmp_se_i(cmp_se_i),
    .cmp_lvd_i(cmp_lvd_i), .cmp_hvd_i(cmp_hvd_i),
    .diffsens_drv_en_o(diffsens_drv_en_o), .drivers_en_o(drivers_en_o),
    .mode_se_o(mode_se_o), .mode_lvd_o(mode_lvd_o), .mode_hvd_o(mode_hvd_o),
    .term_lvd_en_o(term_lvd_en_o), .term_se_en_o(term_se_en_o),
    .gnd_drv_en_o(gnd_drv_en_o), .ready_o(ready_o));

// ---- dv/dsmd_bus_model.sv ----
// dsmd_bus_model.sv: diffsens line seen through band comparators
// assumes the line level is given in millivolts
`timescale 1ns/1ps

module dsmd_bus_model (
    // line level
    input wire logic [12:0] mv_i,
    // comparator bands
    output logic cmp_se_o,
    output logic cmp_lvd_o,
    output logic cmp_hvd_o
);
    // gap levels leave every band low
    assign cmp_se_o = (mv_i <= 13'h1f4);
    assign cmp_lvd_o = (mv_i >= 13'h2bc) && (mv_i <= 13'h76c);
    assign cmp_hvd_o = (mv_i >= 13'h960);
endmodule : dsmd_bus_model

// ---- dv/tb.sv ----
// tb.sv: self-checking bench for the mode detector
// assumes a short qualification count of 8 cycles
`timescale 1ns/1ps

module tb;
    localparam int QC = 8;
    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [12:0] mv = 13'h3e8;
    logic cse, clvd, chvd, dsrc, drv, mse, mlvd, mhvd, tlvd, tse, gnd, rdy;
    int err_count = 0;
    int samples_checked = 0;
    always #25 core_clk_i = ~core_clk_i;
    dsmd_bus_model bus_u (.mv_i(mv), .cmp_se_o(cse), .cmp_lvd_o(clvd),
        .cmp_hvd_o(chvd));
    dsmd_detect #(.QUAL_CYC(QC)) dut_u (.core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i), .cmp_se_i(cse), .cmp_lvd_i(clvd),
        .cmp_hvd_i(chvd), .diffsens_drv_en_o(dsrc), .drivers_en_o(drv),
        .mode_se_o(mse), .mode_lvd_o(mlvd), .mode_hvd_o(mhvd),
        .term_lvd_en_o(tlvd), .term_se_en_o(tse), .gnd_drv_en_o(gnd),
        .ready_o(rdy));
    //////////////////////////////
    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // waits for {ready, drivers, hvd, lvd, se}
    task wait_st(input logic [4:0] exp, output int n);
        n = 0;
        while ({rdy, drv, mhvd, mlvd, mse} !== exp && n < 200)
        begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
    endtask : wait_st
    task t_power;
        int n;
        wait_st(5'h1a, n);
        chk(8'(n >= 2*QC && n <= 2*QC+7), 8'h1);
        chk(8'({tlvd, tse, gnd, dsrc}), 8'h9);
        $display("t_power done");
    endtask : t_power
    task t_glitch;
        @(posedge core_clk_i);
        mv <= 13'h0;
        repeat (QC-3) @(posedge core_clk_i);
        mv <= 13'h258;
        @(posedge core_clk_i);
        mv <= 13'h0;
        repeat (QC-3) @(posedge core_clk_i);
        mv <= 13'h3e8;
        repeat (20)
        begin
            @(posedge core_clk_i);
            #1;
            chk(8'({rdy, drv, mhvd, mlvd, mse}), 8'h1a);
        end
        $display("t_glitch done");
    endtask : t_glitch
    task t_se;
        int n;
        @(posedge core_clk_i);
        mv <= 13'h0;
        wait_st(5'h19, n);
        chk(8'(n >= QC && n <= QC+6), 8'h1);
        chk(8'({tlvd, tse, gnd, dsrc}), 8'h7);
        $display("t_se done");
    endtask : t_se
    task t_hvd;
        int n;
        @(posedge core_clk_i);
        mv <= 13'hbb8;
        wait_st(5'h14, n);
        chk(8'(n >= QC && n <= QC+6), 8'h1);
        chk(8'({tlvd, tse, gnd, dsrc}), 8'h1);
        @(posedge core_clk_i);
        mv <= 13'h834;
        repeat (30)
        begin
            @(posedge core_clk_i);
            #1;
            chk(8'({rdy, drv, mhvd, mlvd, mse}), 8'h14);
        end
        @(posedge core_clk_i);
        mv <= 13'h3e8;
        wait_st(5'h1a, n);
        chk(8'(n >= QC && n <= QC+7), 8'h1);
        $display("t_hvd done");
    endtask : t_hvd
    task stop_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    initial
    begin
        #(3000 * 50);
        err_count++;
        stop_test();
    end
    initial
    begin
        repeat (8) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        t_power();
        t_glitch();
        t_se();
        t_hvd();
        stop_test();
    end
endmodule : tb
